/* File: verilog/pscd_pkg.sv */
// shared constants and types for the power save and clock doubler block
package pscd_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] PSCD_PWRCTL_IDX = 8'h87;
  localparam logic [7:0] PSCD_FLSTAT_IDX = 8'hB6;
  localparam logic [7:0] PSCD_WCFG_IDX  = 8'hC0;
  localparam logic [7:0] PSCD_MSTAT_IDX = 8'hC1;

  // power control register fields
  localparam int PSCD_IDLE_REQ_POS  = 0;
  localparam int PSCD_PWRDN_REQ_POS = 1;

  // flash status register fields and reset pattern
  localparam int         PSCD_SECURE_POS   = 6;
  localparam int         PSCD_DBLCLK_POS   = 3;
  localparam int         PSCD_FZERO_POS    = 2;
  localparam logic [7:0] PSCD_FLSTAT_RESET = 8'h00;

  // wake configuration register fields
  localparam int         PSCD_EX0_EN_POS  = 0;
  localparam int         PSCD_EX1_EN_POS  = 1;
  localparam int         PSCD_EX0_LVL_POS = 2;
  localparam int         PSCD_EX1_LVL_POS = 3;
  localparam int         PSCD_GLB_EN_POS  = 7;
  localparam logic [7:0] PSCD_WCFG_RESET  = 8'h00;

  // mode status register fields
  localparam int PSCD_ST_IDLE_POS = 0;
  localparam int PSCD_ST_PD_POS   = 1;
  localparam int PSCD_ST_WAKE_POS = 2;

  // machine cycle lengths and wake low-hold count
  localparam int PSCD_STD_CLKS  = 12;
  localparam int PSCD_DBL_CLKS  = 6;
  localparam int PSCD_LOW_HOLD  = 1024;

  // power modes
  typedef enum logic [2:0] {
    PSCD_RUN    = 3'b000,
    PSCD_IDLE   = 3'b001,
    PSCD_PDOWN  = 3'b010,
    PSCD_WAKE   = 3'b011,
    PSCD_RESUME = 3'b100
  } pscd_state_t;

endpackage : pscd_pkg

/* File: verilog/pscd_mcycle.sv */
// machine cycle timer: 12 or 6 oscillator clocks per machine cycle
`timescale 1ns/1ps
`default_nettype none
module pscd_mcycle
  import pscd_pkg::*;
#(
  parameter int STD_CLKS = PSCD_STD_CLKS,
  parameter int DBL_CLKS = PSCD_DBL_CLKS
)(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       double_mode,
  output logic            mc_tick,
  output logic [3:0]      mc_phase
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } pscd_mc_t;

  pscd_mc_t r_reg;
  pscd_mc_t r_next;
  logic [3:0] last;

  // last phase of the cycle depends on the doubling mode
  always_comb
  begin
    last   = double_mode ? 4'(DBL_CLKS - 1) : 4'(STD_CLKS - 1); // [R14]
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (run)
    begin
      if (r_reg.cnt >= last)
      begin
        r_next.cnt  = 4'h0;
        r_next.tick = 1'b1;
      end
      else
        r_next.cnt = r_reg.cnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      r_reg <= '{cnt: 4'h0, tick: 1'b0};
    else
      r_reg <= r_next;
  end

  assign mc_tick  = r_reg.tick;
  assign mc_phase = r_reg.cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // six clocks between ticks in double mode
  dbl_spacing_a: assert property ( // [R14]
    (mc_tick && double_mode && run) |=> (!mc_tick)[*5])
    else $error("double mode tick came early");

  // eight quiet clocks in standard mode unless doubling switches on
  std_spacing_a: assert property ( // [R14]
    (mc_tick && !double_mode && run)
      |=> (!mc_tick || double_mode)[*8])
    else $error("standard mode tick came early");

endmodule : pscd_mcycle
`default_nettype wire

/* File: verilog/pscd_top.sv */
// power mode controller, wake timer and flash status register
//
// How it works
// R1: writing the power-down bit stops the system clock.
// R2: in power-down only enabled level external interrupts are seen.
// R3: all registers keep their values through power-down.
// R4: power-down ends only on enabled level interrupt or hardware reset.
// R5: start of the waking interrupt clears the power-down bit.
// R6: the waking pin must stay low 1024 clocks before going high.
// R7: after the return, code resumes after the power-down instruction.
// R8: hardware reset in power-down restarts as a power-on reset.
// R9: address latch and fetch strobes are low during power-down.
// R10: writing the idle bit enters idle.
// R11: idle halts the program counter; clock and peripherals keep running.
// R12: address latch and fetch strobes are high during idle.
// R13: any enabled interrupt or reset ends idle; service clears idle bit.
// R14: machine cycle is 12 clocks, or 6 with doubling.
// R15: doubling set by programmer or in-app write; flag reads one.
// R16: doubling affects only internal clock; oscillator output undoubled.
// R17: flash status holds security in bit 6, doubling in bit 3.
// R18: flash status not bit addressable; bit 2 resets to zero.
// R19: software writes zero to reserved flash status bits.
// R20: wake interrupt service enabled only after the low-hold count.
`timescale 1ns/1ps
`default_nettype none
module pscd_top
  import pscd_pkg::*;
#(
  parameter int LOW_HOLD = PSCD_LOW_HOLD
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  ext_int_n,
  input  wire logic        irq_pending,
  input  wire logic        irq_start,
  input  wire logic        prog_double_clock,
  input  wire logic        prog_security,
  input  wire logic        core_ale,
  input  wire logic        core_program_fetch_strobe_n,
  input  wire logic        oscillator_input,
  output logic             oscillator_output,
  output logic             ale,
  output logic             program_fetch_strobe_n,
  output logic             cpu_halt,
  output logic             sys_clk_en,
  output logic             irq_service_en,
  output logic             double_clock_mode,
  output logic             machine_cycle_tick
);

  localparam int CW = $clog2(LOW_HOLD + 1);

  typedef struct packed {
    pscd_state_t st;
    logic        idle_request_bit;
    logic        powerdown_request_bit;
    logic        inapp_double;
    logic [7:0]  wcfg;
    logic [CW-1:0] low_cnt;
    logic        ack;
    logic [31:0] rdata;
    logic        halt;
    logic        clk_en;
    logic        svc_en;
    logic        ale;
    logic        fetch_n;
  } pscd_regs_t;

  pscd_regs_t r_reg;
  pscd_regs_t r_next;

  logic       req;
  logic       wr_fire;
  logic       wake_src;
  logic       dbl_flag;
  logic [7:0] flstat_val;
  logic [7:0] pwrctl_val;
  logic [7:0] mstat_val;
  logic [7:0] wbyte;

  // byte address decode: upper bits zero, index in bits 9:2
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [7:0]  idx);
    reg_hit = (a[11:10] == 2'h0) && (a[9:2] == idx);
  endfunction : reg_hit

  // an enabled external interrupt set to level mode, pin held low
  function automatic logic lvl_wake(input logic [1:0] pin_n,
                                    input logic [7:0] cfg);
    lvl_wake = cfg[PSCD_GLB_EN_POS] &&
      ((cfg[PSCD_EX0_EN_POS] && cfg[PSCD_EX0_LVL_POS] && !pin_n[0]) ||
       (cfg[PSCD_EX1_EN_POS] && cfg[PSCD_EX1_LVL_POS] && !pin_n[1]));
  endfunction : lvl_wake

  // register read views
  always_comb
  begin
    dbl_flag = prog_double_clock || r_reg.inapp_double; // [R15]
    flstat_val = 8'h00;
    flstat_val[PSCD_SECURE_POS] = prog_security;        // [R17]
    flstat_val[PSCD_DBLCLK_POS] = dbl_flag;             // [R17]
    flstat_val[PSCD_FZERO_POS]  = 1'b0;                 // [R18]
    pwrctl_val = 8'h00;
    pwrctl_val[PSCD_IDLE_REQ_POS]  = r_reg.idle_request_bit;
    pwrctl_val[PSCD_PWRDN_REQ_POS] = r_reg.powerdown_request_bit;
    mstat_val = 8'h00;
    mstat_val[PSCD_ST_IDLE_POS] = (r_reg.st == PSCD_IDLE);
    mstat_val[PSCD_ST_PD_POS]   = (r_reg.st == PSCD_PDOWN);
    mstat_val[PSCD_ST_WAKE_POS] = (r_reg.st == PSCD_WAKE);
  end

  // bus handshake terms
  assign req      = avs_read || avs_write;
  assign wr_fire  = avs_write && r_reg.ack && avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign wake_src = lvl_wake(ext_int_n, r_reg.wcfg);  // [R2]

  // next state: bus slave, mode machine, pin overrides
  always_comb
  begin
    r_next = r_reg;
    // one wait cycle, then the answer
    r_next.ack = req && !r_reg.ack;
    if (avs_read && !r_reg.ack)
    begin
      r_next.rdata = 32'h0000_0000;
      if (reg_hit(avs_address, PSCD_PWRCTL_IDX))
        r_next.rdata = {24'h00_0000, pwrctl_val};
      else if (reg_hit(avs_address, PSCD_FLSTAT_IDX))
        r_next.rdata = {24'h00_0000, flstat_val};
      else if (reg_hit(avs_address, PSCD_WCFG_IDX))
        r_next.rdata = {24'h00_0000, r_reg.wcfg};
      else if (reg_hit(avs_address, PSCD_MSTAT_IDX))
        r_next.rdata = {24'h00_0000, mstat_val};
    end

    // power mode sequencing
    case (r_reg.st)
      PSCD_RUN:
      begin
        if (r_reg.powerdown_request_bit)
          r_next.st = PSCD_PDOWN;                       // [R1]
        else if (r_reg.idle_request_bit)
          r_next.st = PSCD_IDLE;                        // [R10]
      end
      PSCD_IDLE:
      begin
        if (irq_pending)
          r_next.st = PSCD_RESUME;                      // [R13]
      end
      PSCD_PDOWN:
      begin
        r_next.low_cnt = '0;
        if (wake_src)
          r_next.st = PSCD_WAKE;                        // [R4]
      end
      PSCD_WAKE:
      begin
        // count restarted oscillator clocks while the pin is low
        if (wake_src)
        begin
          if (r_reg.low_cnt < CW'(LOW_HOLD))
            r_next.low_cnt = r_reg.low_cnt + CW'(1);   // [R20]
        end
        else if (r_reg.low_cnt >= CW'(LOW_HOLD))
          r_next.st = PSCD_RESUME;                      // [R6]
        else
          r_next.st = PSCD_PDOWN;                       // [R20]
      end
      PSCD_RESUME:
      begin
        // service start clears both requests; return goes to next op
        if (irq_start)
        begin
          r_next.st = PSCD_RUN;                         // [R7]
          r_next.powerdown_request_bit = 1'b0;          // [R5]
          r_next.idle_request_bit      = 1'b0;          // [R13]
        end
      end
      default:
        r_next.st = PSCD_RUN;
    endcase

    // software writes; a request written with the clear still lands
    if (wr_fire && reg_hit(avs_address, PSCD_PWRCTL_IDX))
    begin
      r_next.idle_request_bit      = wbyte[PSCD_IDLE_REQ_POS];
      r_next.powerdown_request_bit = wbyte[PSCD_PWRDN_REQ_POS];
    end
    if (wr_fire && reg_hit(avs_address, PSCD_FLSTAT_IDX))
      r_next.inapp_double = wbyte[PSCD_DBLCLK_POS];     // [R15]
    if (wr_fire && reg_hit(avs_address, PSCD_WCFG_IDX))
      r_next.wcfg = wbyte;

    // pin and clock views follow the next mode
    r_next.halt   = 1'b0;
    r_next.clk_en = 1'b1;
    r_next.svc_en = 1'b1;
    r_next.ale    = core_ale;
    r_next.fetch_n = core_program_fetch_strobe_n;
    case (r_next.st)
      PSCD_IDLE:
      begin
        r_next.halt   = 1'b1;                           // [R11]
        r_next.ale    = 1'b1;                           // [R12]
        r_next.fetch_n = 1'b1;                          // [R12]
      end
      PSCD_PDOWN, PSCD_WAKE:
      begin
        r_next.halt   = 1'b1;
        r_next.clk_en = 1'b0;                           // [R1]
        r_next.svc_en = 1'b0;                           // [R20]
        r_next.ale    = 1'b0;                           // [R9]
        r_next.fetch_n = 1'b0;                          // [R9]
      end
      default:
      begin
        r_next.halt = 1'b0;
      end
    endcase
  end

  // state register; reset acts the same from any mode
  always_ff @(posedge core_clk)
  begin
    if (rst)                                            // [R8]
    begin
      r_reg.st                    <= PSCD_RUN;
      r_reg.idle_request_bit      <= 1'b0;
      r_reg.powerdown_request_bit <= 1'b0;
      r_reg.inapp_double          <= PSCD_FLSTAT_RESET[PSCD_DBLCLK_POS];
      r_reg.wcfg                  <= PSCD_WCFG_RESET;
      r_reg.low_cnt               <= '0;
      r_reg.ack                   <= 1'b0;
      r_reg.rdata                 <= 32'h0000_0000;
      r_reg.halt                  <= 1'b0;
      r_reg.clk_en                <= 1'b1;
      r_reg.svc_en                <= 1'b1;
      r_reg.ale                   <= 1'b1;
      r_reg.fetch_n               <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // machine cycle timer runs only on the internal system clock
  pscd_mcycle #(
    .STD_CLKS    (PSCD_STD_CLKS),
    .DBL_CLKS    (PSCD_DBL_CLKS)
  ) u_mcycle (
    .core_clk    (core_clk),
    .rst         (rst),
    .run         (r_reg.clk_en),
    .double_mode (dbl_flag),                            // [R14]
    .mc_tick     (machine_cycle_tick),
    .mc_phase    ()
  );

  // outputs
  assign avs_waitrequest        = req && !r_reg.ack;
  assign avs_readdata           = r_reg.rdata;
  assign oscillator_output      = oscillator_input;     // [R16]
  assign ale                    = r_reg.ale;
  assign program_fetch_strobe_n = r_reg.fetch_n;
  assign cpu_halt               = r_reg.halt;
  assign sys_clk_en             = r_reg.clk_en;
  assign irq_service_en         = r_reg.svc_en;
  assign double_clock_mode      = dbl_flag;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence pwrdn_entered_s;
    (r_reg.st == PSCD_PDOWN) && !sys_clk_en;
  endsequence

  sequence wake_short_s;
    (r_reg.st == PSCD_WAKE) && !wake_src &&
      (r_reg.low_cnt < CW'(LOW_HOLD));
  endsequence

  // power-down request stops the clock one edge later
  pwrdn_entry_a: assert property ( // [R1]
    (r_reg.st == PSCD_RUN && r_reg.powerdown_request_bit)
      |=> pwrdn_entered_s)
    else $error("power-down did not stop the clock");

  // without a level wake source power-down holds
  pwrdn_no_wake_a: assert property ( // [R4]
    (r_reg.st == PSCD_PDOWN && !wake_src) |=> (r_reg.st == PSCD_PDOWN))
    else $error("power-down left without level wake");

  // wake configuration and power-down bit keep their values while asleep
  pwrdn_keeps_regs_a: assert property ( // [R3]
    (r_reg.st == PSCD_PDOWN && !avs_write)
      |=> $stable(r_reg.wcfg) && $stable(r_reg.powerdown_request_bit))
    else $error("register changed in power-down");

  // short low pulse falls back to power-down
  wake_short_a: assert property ( // [R20]
    wake_short_s |=> (r_reg.st == PSCD_PDOWN) && !irq_service_en)
    else $error("wake accepted before the low hold");

  // service start clears both request bits and resumes
  svc_clear_a: assert property ( // [R5]
    (r_reg.st == PSCD_RESUME && irq_start && !wr_fire)
      |=> (r_reg.st == PSCD_RUN) && !r_reg.powerdown_request_bit
          && !r_reg.idle_request_bit)
    else $error("service start did not clear requests");

  // strobes low while asleep
  pwrdn_strobes_a: assert property ( // [R9]
    (r_reg.st == PSCD_PDOWN || r_reg.st == PSCD_WAKE)
      |-> !ale && !program_fetch_strobe_n && cpu_halt)
    else $error("strobes not low in power-down");

  // idle: strobes high, clock running, core halted
  idle_pins_a: assert property ( // [R12]
    (r_reg.st == PSCD_IDLE)
      |-> ale && program_fetch_strobe_n && cpu_halt && sys_clk_en)
    else $error("idle pin levels wrong");

  // pending interrupt ends idle within one edge
  idle_exit_a: assert property ( // [R13]
    (r_reg.st == PSCD_IDLE && irq_pending)
      |=> (r_reg.st == PSCD_RESUME) && !cpu_halt)
    else $error("interrupt did not end idle");

  // flag and status bit 2 as read back
  fst_read_a: assert property ( // [R18]
    (avs_read && !r_reg.ack && reg_hit(avs_address, PSCD_FLSTAT_IDX))
      |=> !avs_readdata[PSCD_FZERO_POS]
          && (avs_readdata[PSCD_DBLCLK_POS] == $past(dbl_flag)))
    else $error("flash status readback wrong");

  // every request answered after exactly one wait cycle
  bus_answer_a: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus request not answered");

endmodule : pscd_top
`default_nettype wire

/* File: verification/pscd_pin_model.sv */
// far side model: wake pin driver and interrupt service start
`timescale 1ns/1ps
`default_nettype none
module pscd_pin_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] hold_len,
  input  wire logic        irq_service_en,
  output logic      [1:0]  ext_int_n,
  output logic             irq_start
);
  logic [15:0] cnt_reg;
  logic        armed_reg;

  // pin 0 held low for hold_len clocks, pin 1 idles high
  always_ff @(posedge core_clk)
  begin
    irq_start    <= 1'h0;
    ext_int_n[1] <= 1'h1;
    if (rst)
    begin
      cnt_reg      <= 16'h0000;
      armed_reg    <= 1'h0;
      ext_int_n[0] <= 1'h1;
    end
    else if (go)
    begin
      cnt_reg      <= hold_len;
      armed_reg    <= 1'h1;
      ext_int_n[0] <= 1'h0;
    end
    else if (cnt_reg != 16'h0000)
    begin
      cnt_reg <= cnt_reg - 16'h0001;
      if (cnt_reg == 16'h0001)
        ext_int_n[0] <= 1'h1;
    end
    else if (armed_reg && irq_service_en)
    begin
      irq_start <= 1'h1;            // one-cycle service start pulse
      armed_reg <= 1'h0;
    end
  end
endmodule : pscd_pin_model
`default_nettype wire

/* File: verification/pscd_top_tb_top.sv */
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pscd_top_tb_top;
  import pscd_pkg::*;
  localparam int HOLD = 16;
  logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [1:0]  ext_int_n;
  logic        irq_pending, irq_start, prog_double_clock, prog_security;
  logic        core_ale, core_fetch_n, oscillator_input, oscillator_output;
  logic        ale, fetch_n, cpu_halt, sys_clk_en, irq_service_en;
  logic        double_clock_mode, machine_cycle_tick, go;
  logic [15:0] hold_len;
  logic [7:0]  rq;
  int          g;
  int          bad_count = 0;
  int          n_checks = 0;

  always #10 core_clk = ~core_clk;

  pscd_top #(.LOW_HOLD(HOLD)) u_dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_int_n(ext_int_n), .irq_pending(irq_pending),
    .irq_start(irq_start), .prog_double_clock(prog_double_clock),
    .prog_security(prog_security), .core_ale(core_ale),
    .core_program_fetch_strobe_n(core_fetch_n),
    .oscillator_input(oscillator_input),
    .oscillator_output(oscillator_output), .ale(ale),
    .program_fetch_strobe_n(fetch_n), .cpu_halt(cpu_halt),
    .sys_clk_en(sys_clk_en), .irq_service_en(irq_service_en),
    .double_clock_mode(double_clock_mode),
    .machine_cycle_tick(machine_cycle_tick));

  pscd_pin_model u_pins (
    .core_clk(core_clk), .rst(rst), .go(go), .hold_len(hold_len),
    .irq_service_en(irq_service_en), .ext_int_n(ext_int_n),
    .irq_start(irq_start));

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  // halt, clock enable, service enable, address strobe, fetch strobe
  task mode(input logic [4:0] exp);
    #1;
    chk({27'h0, cpu_halt, sys_clk_en, irq_service_en, ale, fetch_n},
        {27'h0, exp}, "mode outputs");
    @(posedge core_clk);
  endtask : mode

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // one Avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= {2'h0, idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 50);
    rq = avs_readdata[7:0];
    if (n >= 50)
      chk(32'h1, 32'h0, "bus hang");
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : bus

  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk({24'h0, rq}, {24'h0, exp}, "register read");
  endtask : rd_chk

  task pulse(input int n);
    go       <= 1'h1;
    hold_len <= n[15:0];
    cyc(1);
    go       <= 1'h0;
  endtask : pulse

  // cycles between two machine cycle ticks
  task gap;
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (machine_cycle_tick !== 1'h1 && n < 40);
    g = 0;
    do
    begin
      @(posedge core_clk);
      g++;
    end
    while (machine_cycle_tick !== 1'h1 && g < 40);
  endtask : gap

  task t_reset;
    mode(5'h0F);
    rd_chk(PSCD_PWRCTL_IDX, 8'h00);
    rd_chk(PSCD_FLSTAT_IDX, 8'h40);
    rd_chk(PSCD_WCFG_IDX, 8'h00);
    bus(1'h1, 8'h10, 8'hA5);
    rd_chk(8'h10, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_clock;
    gap();
    chk(g, PSCD_STD_CLKS, "standard period");
    prog_double_clock <= 1'h1;
    gap();
    gap();
    chk(g, PSCD_DBL_CLKS, "double period");
    rd_chk(PSCD_FLSTAT_IDX, 8'h48);
    prog_double_clock <= 1'h0;
    bus(1'h1, PSCD_FLSTAT_IDX, 8'h08);
    oscillator_input <= 1'h1;
    #1;
    chk(double_clock_mode, 1'h1, "software double");
    chk(oscillator_output, 1'h1, "osc high");
    bus(1'h1, PSCD_FLSTAT_IDX, 8'h00);
    oscillator_input <= 1'h0;
    #1;
    chk(oscillator_output, 1'h0, "osc low");
    chk(double_clock_mode, 1'h0, "software single");
    $display("test clock done");
  endtask : t_clock

  task t_idle;
    bus(1'h1, PSCD_PWRCTL_IDX, 8'h01);
    cyc(1);
    mode(5'h1F);
    gap();
    chk(g, PSCD_STD_CLKS, "idle ticks");
    irq_pending <= 1'h1;
    cyc(1);
    irq_pending <= 1'h0;
    pulse(1);
    cyc(6);
    mode(5'h0F);
    rd_chk(PSCD_PWRCTL_IDX, 8'h00);
    $display("test idle done");
  endtask : t_idle

  task t_pdown;
    bus(1'h1, PSCD_WCFG_IDX, 8'h85);
    bus(1'h1, PSCD_PWRCTL_IDX, 8'h02);
    cyc(1);
    mode(5'h10);
    irq_pending <= 1'h1;
    cyc(4);
    irq_pending <= 1'h0;
    mode(5'h10);
    pulse(HOLD / 2);
    cyc(HOLD);
    mode(5'h10);
    pulse(HOLD + 4);
    cyc(HOLD);
    mode(5'h10);
    cyc(12);
    mode(5'h0F);
    rd_chk(PSCD_PWRCTL_IDX, 8'h00);
    rd_chk(PSCD_WCFG_IDX, 8'h85);
    $display("test power-down done");
  endtask : t_pdown

  task t_edge_reset;
    bus(1'h1, PSCD_WCFG_IDX, 8'h81);
    bus(1'h1, PSCD_PWRCTL_IDX, 8'h02);
    pulse(HOLD + 4);
    cyc(HOLD + 12);
    mode(5'h10);
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    cyc(1);
    mode(5'h0F);
    rd_chk(PSCD_PWRCTL_IDX, 8'h00);
    rd_chk(PSCD_WCFG_IDX, 8'h00);
    $display("test edge and reset done");
  endtask : t_edge_reset

  // watchdog against a hang
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    core_clk = 1'h0;
    rst = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    irq_pending = 1'h0;
    prog_double_clock = 1'h0;
    prog_security = 1'h1;
    core_ale = 1'h1;
    core_fetch_n = 1'h1;
    oscillator_input = 1'h0;
    go = 1'h0;
    hold_len = 16'h0000;
    cyc(20);
    rst <= 1'h0;
    cyc(1);
    t_reset();
    t_clock();
    t_idle();
    t_pdown();
    t_edge_reset();
    give_verdict();
  end
endmodule : pscd_top_tb_top
`default_nettype wire
